// File: core/sapd_top.sv
// Powerdown controller of a three-driver, three-receiver serial line transceiver.
//
// Behaviour
// - Thirty seconds without any driver or receiver data input edge switches off charge pump and drivers.
// - In automatic powerdown, any driver or receiver input edge powers back up.
// - Inactivity powerdown works only with force-active low and force-shutdown high.
// - Force-active high blocks inactivity powerdown; force-shutdown low always powers down.
// - Any powerdown leaves the timer expired until force-active rises or an edge.
// - Flag drops after invalid levels persist on all receivers over 30 us.
// - The signal-present flag never changes power state by itself.
// - Recovery from powerdown to active drivers takes 100 us.
// - Flag rises 1 us after any receiver sees a valid level.
// - The flag keeps working in every power state.
// - Flag on force-shutdown: after cable return, wake needs a fresh edge.
// - In powerdown the drivers float while receivers keep working.
// - After force-active falls the part stays up a full 30 seconds.
`timescale 1ns/1ps
`default_nettype none
`include "sapd_cfg.svh"

module sapd_top
    import sapd_pkg::*;
#(
    parameter logic [31:0] IDLE_CYCLES = 32'(`SAPD_IDLE_CYC),
    parameter logic [15:0] WAKE_CYCLES = 16'(`SAPD_WAKE_CYC)
) (
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Host control inputs.
    input  wire logic              force_active_in,
    input  wire logic              force_shutdown_in,
    // Monitored line inputs.
    input  wire sapd_pkg::sapd_line_t line_in,
    // Line driver outputs and receiver outputs.
    output var sapd_pkg::sapd_drive_t tx_out,
    output logic [2:0]             rx_out,
    // Status.
    output logic                   sig_present,
    output logic                   pump_en,
    output logic                   pwr_active
);
    import sapd_pkg::*;

    localparam logic [11:0] INVALID_CYC = 12'(`SAPD_INVALID_CYC);
    localparam logic [7:0]  VALID_CYC   = 8'(`SAPD_VALID_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.

    sapd_line_t line_s;
    logic [1:0] ctl_s;
    logic       fa_s;
    logic       fsd_s;

    sapd_sync #(.WIDTH(9)) u_line_sync (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .async_in   (line_in),
        .stable_out (line_s)
    );

    sapd_sync #(.WIDTH(2)) u_ctl_sync (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .async_in   ({force_active_in, force_shutdown_in}),
        .stable_out (ctl_s)
    );

    assign fa_s  = ctl_s[1];
    assign fsd_s = ctl_s[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Activity detection on driver and receiver data inputs.

    logic [5:0] act_prev_q;
    logic [5:0] act_prev_d;
    logic       activity;

    always_comb begin
        act_prev_d = {line_s.drv, line_s.rx};
        activity   = (act_prev_d != act_prev_q);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            act_prev_q <= 6'h00;
        end else begin
            act_prev_q <= act_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Inactivity timer. It saturates in the expired state until something restarts it.

    logic [31:0] idle_cnt_q;
    logic [31:0] idle_cnt_d;
    logic        expired_q;
    logic        expired_d;

    always_comb begin
        idle_cnt_d = idle_cnt_q;
        expired_d  = expired_q;
        if (!fsd_s) begin
            expired_d = 1'b1;
        end else if (fa_s) begin
            // Held clear while forced on, so the full interval runs after the fall.
            idle_cnt_d = 32'h0000_0000;
            expired_d  = 1'b0;
        end else if (activity) begin
            idle_cnt_d = 32'h0000_0000;
            expired_d  = 1'b0;
        end else if (!expired_q) begin
            if (idle_cnt_q >= IDLE_CYCLES - 32'h1) begin
                expired_d = 1'b1;
            end else begin
                idle_cnt_d = idle_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idle_cnt_q <= 32'h0000_0000;
            expired_q  <= 1'b0;
        end else begin
            idle_cnt_q <= idle_cnt_d;
            expired_q  <= expired_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state. The signal-present flag is deliberately not an input here.

    sapd_state_t state_q;
    sapd_state_t state_d;
    logic [15:0] wake_cnt_q;
    logic [15:0] wake_cnt_d;
    logic        down_req;

    always_comb begin
        down_req   = !fsd_s || (!fa_s && expired_q);
        state_d    = state_q;
        wake_cnt_d = wake_cnt_q;
        if (down_req) begin
            state_d    = SAPD_ST_DOWN;
            wake_cnt_d = 16'h0000;
        end else begin
            unique case (state_q)
                SAPD_ST_DOWN: begin
                    state_d    = SAPD_ST_RAMP;
                    wake_cnt_d = 16'h0000;
                end
                SAPD_ST_RAMP: begin
                    // The pump needs time to build its rails before drivers may enable.
                    if (wake_cnt_q >= WAKE_CYCLES - 16'h1) begin
                        state_d = SAPD_ST_ACTIVE;
                    end else begin
                        wake_cnt_d = wake_cnt_q + 16'h1;
                    end
                end
                SAPD_ST_ACTIVE: begin
                    state_d = SAPD_ST_ACTIVE;
                end
                default: begin
                    state_d = SAPD_ST_DOWN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q    <= SAPD_ST_DOWN;
            wake_cnt_q <= 16'h0000;
        end else begin
            state_q    <= state_d;
            wake_cnt_q <= wake_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Signal-present flag, running in every power state.

    logic [11:0] inv_cnt_q;
    logic [11:0] inv_cnt_d;
    logic [7:0]  val_cnt_q;
    logic [7:0]  val_cnt_d;
    logic        present_q;
    logic        present_d;
    logic        any_valid;

    always_comb begin
        any_valid = |line_s.rx_valid;
        inv_cnt_d = inv_cnt_q;
        val_cnt_d = val_cnt_q;
        present_d = present_q;
        if (any_valid) begin
            inv_cnt_d = 12'h000;
            if (val_cnt_q >= VALID_CYC - 8'h1) begin
                present_d = 1'b1;
            end else begin
                val_cnt_d = val_cnt_q + 8'h1;
            end
        end else begin
            val_cnt_d = 8'h00;
            // Strictly more than the interval: one extra cycle past the count.
            if (inv_cnt_q >= INVALID_CYC) begin
                present_d = 1'b0;
            end else begin
                inv_cnt_d = inv_cnt_q + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inv_cnt_q <= 12'h000;
            val_cnt_q <= 8'h00;
            present_q <= `SAPD_PRESENT_RST;
        end else begin
            inv_cnt_q <= inv_cnt_d;
            val_cnt_q <= val_cnt_d;
            present_q <= present_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs. Drivers invert and float unless fully active; receivers always run.

    sapd_drive_t drive_q;
    sapd_drive_t drive_d;
    logic [2:0]  rx_out_q;
    logic [2:0]  rx_out_d;
    logic        pump_q;
    logic        pump_d;

    always_comb begin
        drive_d.data = ~line_s.drv;
        drive_d.oe   = (state_q == SAPD_ST_ACTIVE) ? 3'h7 : 3'h0;
        rx_out_d     = ~line_s.rx;
        pump_d       = (state_q != SAPD_ST_DOWN);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive_q  <= '0;
            rx_out_q <= 3'h0;
            pump_q   <= 1'b0;
        end else begin
            drive_q  <= drive_d;
            rx_out_q <= rx_out_d;
            pump_q   <= pump_d;
        end
    end

    assign tx_out      = drive_q;
    assign rx_out      = rx_out_q;
    assign sig_present = present_q;
    assign pump_en     = pump_q;
    assign pwr_active  = drive_q.oe[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_manual_down: assert property (!fsd_s |=> state_q == SAPD_ST_DOWN ##1 tx_out.oe == 3'h0)
        else $error("force-shutdown low did not power down");
    chk_force_clear: assert property (fsd_s && fa_s |=> !expired_q && idle_cnt_q == 32'h0)
        else $error("timer not held clear while forced on");
    chk_idle_expire: assert property (fsd_s && !fa_s && !activity && !expired_q
                                      && idle_cnt_q == IDLE_CYCLES - 32'h1
                                      |=> expired_q ##1 state_q == SAPD_ST_DOWN)
        else $error("idle interval did not power down");
    chk_wake_edge: assert property (state_q == SAPD_ST_DOWN && activity && fsd_s
                                    |=> !expired_q ##1 state_q == SAPD_ST_RAMP)
        else $error("edge did not wake the part");
    chk_hold_down: assert property (expired_q && fsd_s && !fa_s && !activity
                                    |=> expired_q)
        else $error("expired timer released without cause");
    chk_ramp_time: assert property ($rose(state_q == SAPD_ST_ACTIVE)
                                    |-> $past(wake_cnt_q) == WAKE_CYCLES - 16'h1)
        else $error("wake ramp length wrong");
    chk_tx_float: assert property (state_q != SAPD_ST_ACTIVE |=> tx_out.oe == 3'h0 && pwr_active == 1'b0)
        else $error("drivers enabled outside active state");
    chk_flag_drop: assert property (!any_valid && inv_cnt_q == INVALID_CYC |=> !sig_present)
        else $error("flag did not drop after invalid interval");
    chk_flag_rise: assert property (any_valid && val_cnt_q == VALID_CYC - 8'h1 |=> sig_present)
        else $error("flag did not rise after valid delay");
    chk_flag_early: assert property ($rose(sig_present) |-> $past(val_cnt_q) == VALID_CYC - 8'h1)
        else $error("flag rose without the valid delay");

endmodule : sapd_top
`default_nettype wire

// File: core/sapd_cfg.svh
// Timing counts and reset values for the serial auto powerdown controller.
`ifndef SAPD_CFG_SVH
`define SAPD_CFG_SVH

// Reference clock rate in hertz.
`define SAPD_CLK_HZ        64'd125000000
`define SAPD_NS_PER_S      64'd1000000000

// Inactivity interval before automatic powerdown, in seconds.
`define SAPD_IDLE_S        64'd30
`define SAPD_IDLE_CYC      (`SAPD_IDLE_S * `SAPD_CLK_HZ)

// Invalid-level persistence before the flag drops, in nanoseconds (least time, rounded up).
`define SAPD_INVALID_NS    64'd30000
`define SAPD_INVALID_CYC   ((`SAPD_INVALID_NS * `SAPD_CLK_HZ + `SAPD_NS_PER_S - 64'd1) / `SAPD_NS_PER_S)

// Valid-level delay before the flag rises, in nanoseconds.
`define SAPD_VALID_NS      64'd1000
`define SAPD_VALID_CYC     ((`SAPD_VALID_NS * `SAPD_CLK_HZ + `SAPD_NS_PER_S - 64'd1) / `SAPD_NS_PER_S)

// Recovery time from powerdown to active drivers, in nanoseconds.
`define SAPD_WAKE_NS       64'd100000
`define SAPD_WAKE_CYC      ((`SAPD_WAKE_NS * `SAPD_CLK_HZ + `SAPD_NS_PER_S - 64'd1) / `SAPD_NS_PER_S)

// Reset values.
`define SAPD_SYNC_RST      1'b0
`define SAPD_PRESENT_RST   1'b0

`endif

// File: core/sapd_pkg.sv
// Types shared by the serial auto powerdown controller.
package sapd_pkg;

    // Monitored line inputs, three of each kind.
    typedef struct packed {
        logic [2:0] drv;      // Driver (transmitter) logic inputs.
        logic [2:0] rx;       // Receiver data after slicing.
        logic [2:0] rx_valid; // Receiver sees a valid line level.
    } sapd_line_t;

    // Line driver side of the outputs.
    typedef struct packed {
        logic [2:0] data;
        logic [2:0] oe;
    } sapd_drive_t;

    // Power states, one-hot.
    typedef enum logic [2:0] {
        SAPD_ST_DOWN   = 3'b001,
        SAPD_ST_RAMP   = 3'b010,
        SAPD_ST_ACTIVE = 3'b100
    } sapd_state_t;

endpackage : sapd_pkg

// File: core/sapd_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
`include "sapd_cfg.svh"

module sapd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Asynchronous input and filtered result.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_d;
    logic [WIDTH-1:0] stable_q;

    // Accept a bit only when the two late stages agree, so one-cycle metastable blips are dropped.
    always_comb begin
        stable_d = stable_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                stable_d[i] = s3_q[i];
            end
        end
    end

    // Stage one feeds only stage two.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q     <= {WIDTH{`SAPD_SYNC_RST}};
            s2_q     <= {WIDTH{`SAPD_SYNC_RST}};
            s3_q     <= {WIDTH{`SAPD_SYNC_RST}};
            stable_q <= {WIDTH{`SAPD_SYNC_RST}};
        end else begin
            s1_q     <= async_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign stable_out = stable_q;

endmodule : sapd_sync
`default_nettype wire

// File: sim/sapd_host.sv
// Host-side power management wiring that drives the two control inputs.
`timescale 1ns/1ps
`default_nettype none
module sapd_host (
    // Wiring choice and bench commands.
    input  wire logic [1:0] mode,
    input  wire logic       fa_cmd,
    input  wire logic       fsd_cmd,
    // Flag from the transceiver and resulting controls.
    input  wire logic       sig_present,
    output logic            force_active_in,
    output logic            force_shutdown_in
);
    // Mode 1 feeds the flag to both controls, mode 2 to shutdown only; mode 0 follows the bench.
    always_comb begin
        case (mode)
            2'h1: begin
                force_active_in   = sig_present;
                force_shutdown_in = sig_present;
            end
            2'h2: begin
                force_active_in   = 1'b0;
                force_shutdown_in = sig_present;
            end
            default: begin
                force_active_in   = fa_cmd;
                force_shutdown_in = fsd_cmd;
            end
        endcase
    end
endmodule : sapd_host
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the serial auto powerdown controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sapd_pkg::*;
    // Short counts keep the run small; flag delays are fixed in the design.
    localparam logic [31:0] IDLE = 32'd200;
    localparam logic [15:0] WAKE = 16'h0014;
    localparam int          INV  = 3751;
    localparam int          VAL  = 125;
    typedef struct {logic [2:0] drv; logic [2:0] rx; logic [5:0] tx; logic [2:0] ro;} sapd_row_t;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [1:0]  mode    = 2'h0;
    logic        fa_cmd  = 1'b0;
    logic        fsd_cmd = 1'b1;
    logic        force_active_in;
    logic        force_shutdown_in;
    sapd_line_t  line_in = '{drv: 3'h0, rx: 3'h0, rx_valid: 3'h7};
    sapd_drive_t tx_out;
    logic [2:0]  rx_out;
    logic        sig_present;
    logic        pump_en;
    logic        pwr_active;
    int          num_errors  = 0;
    int          comparisons = 0;
    int          n;
    sapd_row_t   rows [4] = '{'{3'h0, 3'h7, 6'h3f, 3'h0}, '{3'h5, 3'h2, 6'h17, 3'h5},
                              '{3'h7, 3'h0, 6'h07, 3'h7}, '{3'h2, 3'h5, 6'h2f, 3'h2}};

    // Free-running reference clock.
    always #4 ref_clk = ~ref_clk;

    sapd_host host (.mode(mode), .fa_cmd(fa_cmd), .fsd_cmd(fsd_cmd), .sig_present(sig_present),
                    .force_active_in(force_active_in), .force_shutdown_in(force_shutdown_in));
    sapd_top #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) DUT (
        .ref_clk(ref_clk), .rst(rst), .force_active_in(force_active_in),
        .force_shutdown_in(force_shutdown_in), .line_in(line_in), .tx_out(tx_out),
        .rx_out(rx_out), .sig_present(sig_present), .pump_en(pump_en), .pwr_active(pwr_active));

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // Compares a value seen on the ports against the expectation.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // Checks that a measured delay lies in its window.
    task automatic chk_rng(input string nm, input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chk_rng

    // Waits for power (sel 0) or flag (sel 1) to reach a level; a hang ends the run.
    task automatic wait_for(input int sel, input logic v, input int maxc, output int cnt);
        cnt = 0;
        while (((sel == 0) ? pwr_active : sig_present) !== v) begin
            if (cnt >= maxc) begin
                num_errors++;
                $display("Error wait sel %0d expected %0h seen timeout", sel, v);
                test_done();
            end
            @(negedge ref_clk);
            cnt++;
        end
    endtask : wait_for

    // One edge on a driver input.
    task automatic poke();
        @(negedge ref_clk);
        line_in.drv[0] = ~line_in.drv[0];
    endtask : poke

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the reset value of the shutdown sync leaves the part down until an edge.
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("pwr_active after reset", 32'h0, pwr_active);
        poke();
        wait_for(0, 1'b1, 60, n);
        chk_rng("wake delay", n, WAKE, WAKE + 10);
        // Each row is also an edge, so the part stays up through the table.
        foreach (rows[i]) begin
            line_in.drv = rows[i].drv;
            line_in.rx  = rows[i].rx;
            repeat (6) @(negedge ref_clk);
            chk("tx_out", rows[i].tx, tx_out);
            chk("rx_out", rows[i].ro, rx_out);
            chk("pump_en", 32'h1, pump_en);
        end
        wait_for(0, 1'b0, IDLE + 20, n);
        chk_rng("idle delay", n + 6, IDLE, IDLE + 10);
        chk("tx_out down", 32'h28, tx_out);
        chk("pump_en down", 32'h0, pump_en);
        // A receiver edge wakes the part; receiver outputs keep following meanwhile.
        @(negedge ref_clk);
        line_in.rx = 3'h0;
        repeat (5) @(negedge ref_clk);
        chk("rx_out down", 32'h7, rx_out);
        wait_for(0, 1'b1, WAKE + 16, n);
        fa_cmd = 1'b1;
        repeat (IDLE + 50) @(negedge ref_clk);
        chk("pwr_active forced", 32'h1, pwr_active);
        line_in.rx_valid = 3'h0;
        wait_for(1, 1'b0, INV + 20, n);
        chk_rng("flag drop delay", n, INV, INV + 8);
        repeat (10) @(negedge ref_clk);
        chk("pwr_active flag low", 32'h1, pwr_active);
        fsd_cmd = 1'b0;
        wait_for(0, 1'b0, 10, n);
        chk("oe manual", 32'h0, tx_out.oe);
        line_in.rx_valid = 3'h2;
        wait_for(1, 1'b1, VAL + 20, n);
        chk_rng("flag rise delay", n, VAL, VAL + 8);
        chk("pwr_active manual", 32'h0, pwr_active);
        fa_cmd  = 1'b0;
        fsd_cmd = 1'b1;
        repeat (50) @(negedge ref_clk);
        chk("pwr_active expired", 32'h0, pwr_active);
        fa_cmd = 1'b1;
        wait_for(0, 1'b1, WAKE + 16, n);
        fa_cmd = 1'b0;
        wait_for(0, 1'b0, IDLE + 20, n);
        chk_rng("hold after release", n, IDLE, IDLE + 10);
        // Flag wired to both controls.
        mode = 2'h1;
        wait_for(0, 1'b1, WAKE + 16, n);
        line_in.rx_valid = 3'h0;
        wait_for(1, 1'b0, INV + 20, n);
        wait_for(0, 1'b0, 10, n);
        line_in.rx_valid = 3'h1;
        wait_for(1, 1'b1, VAL + 20, n);
        wait_for(0, 1'b1, WAKE + 16, n);
        // Flag wired to shutdown only: cable return alone must not wake.
        mode = 2'h2;
        line_in.rx_valid = 3'h0;
        // Edges every 100 cycles keep the idle timer off, so only the flag can take the part down.
        for (int k = 0; k < 40; k++) begin
            repeat (100) @(negedge ref_clk);
            if (k == 30) chk("pwr_active cable going", 32'h1, pwr_active);
            line_in.drv[1] = ~line_in.drv[1];
        end
        chk("pwr_active cable out", 32'h0, pwr_active);
        wait_for(1, 1'b0, INV + 20, n);
        wait_for(0, 1'b0, 10, n);
        line_in.rx_valid = 3'h7;
        wait_for(1, 1'b1, VAL + 20, n);
        repeat (60) @(negedge ref_clk);
        chk("pwr_active cable back", 32'h0, pwr_active);
        poke();
        wait_for(0, 1'b1, WAKE + 16, n);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
